// [swpc_regs.svh]
// Offsets, field positions, reset values and timing counts of the system-control block.
`ifndef SWPC_REGS_SVH
`define SWPC_REGS_SVH
// ----------------------------------------
// Register addresses
// ----------------------------------------
`define SWPC_ADDR_PCTL 8'h87
`define SWPC_ADDR_AUX 8'h8E
`define SWPC_ADDR_WDC 8'h8F
// ----------------------------------------
// Field positions
// ----------------------------------------
`define SWPC_POF_BIT 4
`define SWPC_UF1_BIT 3
`define SWPC_UF0_BIT 2
`define SWPC_PD_BIT 1
`define SWPC_IDL_BIT 0
`define SWPC_SOFF_BIT 0
`define SWPC_WEN_BIT 7
`define SWPC_WCLR_BIT 6
`define SWPC_WATCHDOG_IDLE_RUN_BIT 4
`define SWPC_PS_LSB 0
// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define SWPC_REG_RESET 8'h00
`define SWPC_PORT_RESET 8'hFF
`define SWPC_SP_RESET 8'h07
`define SWPC_OSC_PER_MC 12
`define SWPC_LAST_STATE 3'h5
`define SWPC_S5_STATE 3'h4
`define SWPC_WDT_BITS 14
`endif

// [swpc_pkg.sv]
// Types shared by the system-control block.
package swpc_pkg;
    // Register bus request from the core.
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } swpc_sfr_req_t;
    // Read answer to the core.
    typedef struct packed {
        logic [7:0] rdata;
        logic hit;
    } swpc_sfr_rsp_t;
    // All state of the block.
    typedef struct packed {
        logic half;
        logic [2:0] state;
        logic [1:0] rsamp;
        logic rpin;
        logic wrst;
        logic power_off_flag;
        logic uf1;
        logic uf0;
        logic pd;
        logic idle_bit;
        logic soff;
        logic wen;
        logic wclr;
        logic watchdog_idle_run;
        logic [2:0] ps;
        logic [7:0] pre;
        logic [13:0] tmr;
        logic ale;
        logic cpu_en;
        logic osc_run;
        logic gain;
        logic sys_rst;
        swpc_sfr_rsp_t rsp;
    } swpc_state_t;
endpackage

// [swpc_top.sv]
// Watchdog, power control, reset filter and strobe suppression of the controller.
`timescale 1ns/10ps
`default_nettype none
`include "swpc_regs.svh"

module swpc_top import swpc_pkg::*; #(
    // Watchdog timer width; the state field holds at most 14 bits.
    parameter int WDT_BITS = `SWPC_WDT_BITS
) (
    // Clock, power-on reset and freeze.
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic clk_en,
    // Pins and straps.
    input wire logic reset_pin,
    input wire logic osc_gain_setting,
    // Core status.
    input wire logic core_ale,
    input wire logic ext_access,
    input wire logic irq_pending,
    // Register bus.
    input wire swpc_sfr_req_t sfr_req,
    output logic [7:0] sfr_rdata,
    output logic sfr_hit,
    // Control outputs.
    output logic ale_out,
    output logic cpu_clk_en,
    output logic osc_run,
    output logic osc_full_gain,
    output logic sys_reset,
    output logic state_tick
);
    // ----------------------------------------
    // Functions
    // ----------------------------------------
    // Terminal prescaler count for a select code.
    function automatic logic [7:0] ps_mask(input logic [2:0] ps);
        logic [7:0] m;
        m = 8'h01;
        unique case (ps)
            3'h0: m = 8'h01;
            3'h2: m = 8'h03;
            3'h1: m = 8'h07;
            3'h3: m = 8'h0F;
            3'h4: m = 8'h1F;
            3'h5: m = 8'h3F;
            3'h6: m = 8'h7F;
            3'h7: m = 8'hFF;
        endcase
        return m;
    endfunction

    // Register address match.
    function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
        return a == b;
    endfunction

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    swpc_state_t st; // Current state.
    swpc_state_t next_st; // Next state.
    logic mc_end; // Last phase of a machine cycle.
    logic s5p2; // Reset sampling phase.
    logic srst; // Soft reset from pin or watchdog.
    logic wr_pctl; // Write to power control.
    logic wr_aux; // Write to auxiliary control.
    logic wr_wdc; // Write to watchdog control.
    logic wdt_run; // Watchdog counting this cycle.
    logic pre_end; // Prescaler at its terminal count.
    logic timeout; // Watchdog expiry.

    // Timing phases come from the divided clock.
    assign mc_end = st.half && (st.state == `SWPC_LAST_STATE);
    assign s5p2 = st.half && (st.state == `SWPC_S5_STATE);
    assign srst = st.rpin || st.wrst;
    assign wr_pctl = sfr_req.wr && hit(sfr_req.addr, `SWPC_ADDR_PCTL);
    assign wr_aux = sfr_req.wr && hit(sfr_req.addr, `SWPC_ADDR_AUX);
    assign wr_wdc = sfr_req.wr && hit(sfr_req.addr, `SWPC_ADDR_WDC);
    // Watchdog halts in power-down, and in idle unless told to run.
    assign wdt_run = st.wen && !st.pd && (!st.idle_bit || st.watchdog_idle_run) && !srst;
    assign pre_end = st.pre == ps_mask(st.ps);
    assign timeout = wdt_run && mc_end && pre_end && (&st.tmr[WDT_BITS-1:0]);

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    // Computes every register of the block.
    always_comb begin
        next_st = st;
        // Divide by two, then six states per machine cycle.
        next_st.half = !st.half;
        if (st.half) begin
            next_st.state = mc_end ? 3'h0 : st.state + 3'h1;
        end
        // Sample the pin once a machine cycle and filter it.
        if (s5p2) begin
            next_st.rsamp = {st.rsamp[0], reset_pin};
            if (st.rsamp[0] && reset_pin) begin
                next_st.rpin = 1'b1;
            end else if (!reset_pin) begin
                next_st.rpin = 1'b0;
            end
        end
        // Watchdog reset lasts one machine cycle.
        if (mc_end) begin
            next_st.wrst = 1'b0;
        end
        // Register writes.
        if (wr_pctl) begin
            next_st.power_off_flag = sfr_req.wdata[`SWPC_POF_BIT];
            next_st.uf1 = sfr_req.wdata[`SWPC_UF1_BIT];
            next_st.uf0 = sfr_req.wdata[`SWPC_UF0_BIT];
            next_st.pd = sfr_req.wdata[`SWPC_PD_BIT];
            next_st.idle_bit = sfr_req.wdata[`SWPC_IDL_BIT];
        end else if (irq_pending) begin
            next_st.idle_bit = 1'b0;
        end
        if (wr_aux) begin
            next_st.soff = sfr_req.wdata[`SWPC_SOFF_BIT];
        end
        if (wr_wdc) begin
            next_st.wen = sfr_req.wdata[`SWPC_WEN_BIT];
            next_st.wclr = sfr_req.wdata[`SWPC_WCLR_BIT];
            next_st.watchdog_idle_run = sfr_req.wdata[`SWPC_WATCHDOG_IDLE_RUN_BIT];
            next_st.ps = sfr_req.wdata[`SWPC_PS_LSB +: 3];
        end
        // Watchdog chain advances once a machine cycle.
        if (wdt_run && mc_end) begin
            next_st.pre = pre_end ? 8'h00 : st.pre + 8'h01;
            if (pre_end) begin
                next_st.tmr = st.tmr + 14'h0001;
            end
        end
        // Clear request is served at the next cycle boundary; a new write wins.
        if (st.wclr && mc_end && !wr_wdc) begin
            next_st.wclr = 1'b0;
            next_st.pre = 8'h00;
            next_st.tmr = 14'h0000;
        end
        if (timeout) begin
            next_st.wrst = 1'b1;
        end
        // Soft reset reloads defaults but keeps the power-off flag.
        if (srst) begin
            next_st.uf1 = 1'b0;
            next_st.uf0 = 1'b0;
            next_st.pd = 1'b0;
            next_st.idle_bit = 1'b0;
            next_st.soff = 1'b0;
            next_st.wen = 1'b0;
            next_st.wclr = 1'b0;
            next_st.watchdog_idle_run = 1'b0;
            next_st.ps = 3'h0;
            next_st.pre = 8'h00;
            next_st.tmr = 14'h0000;
        end
        // Strobe passes unless suppressed on internal code.
        next_st.ale = core_ale && (!next_st.soff || ext_access);
        next_st.cpu_en = !next_st.idle_bit && !next_st.pd;
        next_st.osc_run = !next_st.pd;
        next_st.gain = osc_gain_setting;
        next_st.sys_rst = next_st.rpin || next_st.wrst;
        // Read answer, zero for an unmapped address.
        next_st.rsp = '0;
        if (sfr_req.rd) begin
            unique case (sfr_req.addr)
                `SWPC_ADDR_PCTL: begin
                    next_st.rsp.hit = 1'b1;
                    next_st.rsp.rdata = {3'h0, st.power_off_flag, st.uf1, st.uf0, st.pd, st.idle_bit};
                end
                `SWPC_ADDR_AUX: begin
                    next_st.rsp.hit = 1'b1;
                    next_st.rsp.rdata = {7'h00, st.soff};
                end
                `SWPC_ADDR_WDC: begin
                    next_st.rsp.hit = 1'b1;
                    next_st.rsp.rdata = {st.wen, st.wclr, 1'b0, st.watchdog_idle_run, 1'b0, st.ps};
                end
                default: begin
                    next_st.rsp = '0;
                end
            endcase
        end
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    // Power-on reset sets the power-off flag; clock enable freezes all.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            st <= '0;
            st.power_off_flag <= 1'b1;
            st.cpu_en <= 1'b1;
            st.osc_run <= 1'b1;
            st.gain <= 1'b1;
        end else if (clk_en) begin
            st <= next_st;
        end
    end

    // Outputs straight from the state register.
    assign sfr_rdata = st.rsp.rdata;
    assign sfr_hit = st.rsp.hit;
    assign ale_out = st.ale;
    assign cpu_clk_en = st.cpu_en;
    assign osc_run = st.osc_run;
    assign osc_full_gain = st.gain;
    assign sys_reset = st.sys_rst;
    assign state_tick = st.half;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    // Clear request seen at a boundary.
    sequence s_clr_due;
        clk_en && st.wclr && mc_end && !wr_wdc;
    endsequence
    // Chain is zero with the bit gone.
    sequence s_cleared;
        st.tmr == 14'h0000 && st.pre == 8'h00 && !st.wclr;
    endsequence
    property p_wdt_clear;
        s_clr_due |=> s_cleared;
    endproperty
    a_wdt_clear: assert property (p_wdt_clear) else $error("watchdog clear not served");

    property p_ale_off;
        clk_en && st.soff && !wr_aux && !srst && !ext_access |=> !ale_out;
    endproperty
    a_ale_off: assert property (p_ale_off) else $error("strobe not suppressed");

    property p_ale_ext;
        clk_en && ext_access && core_ale |=> ale_out;
    endproperty
    a_ale_ext: assert property (p_ale_ext) else $error("strobe missing on external access");

    property p_idle;
        clk_en && st.idle_bit && !srst && !irq_pending |=> !cpu_clk_en;
    endproperty
    a_idle: assert property (p_idle) else $error("core clock runs in idle");

    property p_pd_hold;
        clk_en && st.pd && !srst && !wr_pctl |=> st.pd && !osc_run;
    endproperty
    a_pd_hold: assert property (p_pd_hold) else $error("power-down left without reset");

    property p_timeout;
        clk_en && timeout |=> sys_reset && st.wrst;
    endproperty
    a_timeout: assert property (p_timeout) else $error("time-out gave no reset");

    property p_srst;
        clk_en && srst |=> !st.wen && st.tmr == 14'h0000;
    endproperty
    a_srst: assert property (p_srst) else $error("watchdog survived reset");

    property p_pof_keep;
        clk_en && srst && !wr_pctl |=> st.power_off_flag == $past(st.power_off_flag);
    endproperty
    a_pof_keep: assert property (p_pof_keep) else $error("power-off flag changed by reset");

    property p_glitch;
        clk_en && s5p2 && !st.rsamp[0] && !st.rpin |=> !st.rpin;
    endproperty
    a_glitch: assert property (p_glitch) else $error("single sample caused reset");

    property p_gain;
        clk_en |=> osc_full_gain == $past(osc_gain_setting);
    endproperty
    a_gain: assert property (p_gain) else $error("gain does not follow setting");

    // The divided-clock phase flips at every enabled edge.
    property p_half;
        clk_en |=> state_tick != $past(state_tick);
    endproperty
    a_half: assert property (p_half) else $error("clock phase did not toggle");

    // The timer only steps when the prescaler wraps.
    property p_tmr_step;
        clk_en && wdt_run && mc_end && !pre_end && !st.wclr |=> st.tmr == $past(st.tmr);
    endproperty
    a_tmr_step: assert property (p_tmr_step) else $error("timer stepped before prescaler wrap");
endmodule
`default_nettype wire

// [swpc_core_model.sv]
// Core-side partner: register bus master and reset pin driver.
`timescale 1ns/10ps
`default_nettype none
module swpc_core_model import swpc_pkg::*; (
    // Clock.
    input wire logic mclk,
    // Answer from the block.
    input wire logic [7:0] sfr_rdata,
    input wire logic sfr_hit,
    // Requests to the block.
    output var swpc_sfr_req_t sfr_req,
    output var logic reset_pin
);
    // Bus idle, pin low, from time zero.
    initial begin
        sfr_req = '0;
        reset_pin = 1'b0;
    end
    // One write strobe held for exactly one taken edge; data turned over once released.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk) #1;
        sfr_req = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk) #1;
        sfr_req.wr = 1'b0;
        sfr_req.wdata = ~d;
    endtask
    // One read strobe; the answer is taken just after the taken edge.
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic h);
        @(posedge mclk) #1;
        sfr_req = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge mclk) #1;
        sfr_req.rd = 1'b0;
        d = sfr_rdata;
        h = sfr_hit;
    endtask
    // Holds the pin high for n edges; callers use n of 40 for a real reset.
    task automatic pin(input int n);
        @(posedge mclk) #1;
        reset_pin = 1'b1;
        repeat (n) @(posedge mclk);
        #1;
        reset_pin = 1'b0;
    endtask
endmodule
`default_nettype wire

// [swpc_tb_top.sv]
// Self-checking testbench of the system-control block.
`timescale 1ns/10ps
`default_nettype none
module swpc_tb_top;
    import swpc_pkg::*;
    // Clock, reset and core status lines.
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic gain = 1'b1;
    logic core_ale = 1'b0;
    logic ext_access = 1'b0;
    logic irq_pending = 1'b0;
    logic clk_en = 1'b1;
    // Short timer so a full time-out fits the run; ratio 4 is used for it.
    localparam int WDT_TB_BITS = 2;
    localparam int TO_CYC = (2 ** WDT_TB_BITS) * 4 * 12;
    // Edges spent in the last bounded wait.
    int wait_cycles = 0;
    // Bus and outputs.
    swpc_sfr_req_t sfr_req;
    logic reset_pin, sfr_hit, ale_out, cpu_clk_en, osc_run, osc_full_gain, sys_reset, state_tick;
    logic [7:0] sfr_rdata, d;
    logic h, tick0, seen_rst;
    int errors = 0;
    int check_count = 0;
    // 100 MHz clock.
    always #5 mclk = ~mclk;
    // Latches any system reset seen, for the watchdog clear and glitch tests.
    always @(posedge mclk) if (sys_reset === 1'b1) seen_rst <= 1'b1;
    swpc_top #(.WDT_BITS(WDT_TB_BITS)) dut_u (.mclk(mclk), .reset_n(reset_n), .clk_en(clk_en),
        .reset_pin(reset_pin), .osc_gain_setting(gain), .core_ale(core_ale), .ext_access(ext_access),
        .irq_pending(irq_pending), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
        .ale_out(ale_out), .cpu_clk_en(cpu_clk_en), .osc_run(osc_run),
        .osc_full_gain(osc_full_gain), .sys_reset(sys_reset), .state_tick(state_tick));
    swpc_core_model core_u (.mclk(mclk), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
        .sfr_req(sfr_req), .reset_pin(reset_pin));
    // Prints counts and verdict, then ends the run.
    task automatic tally_and_finish();
        $display("checks=%0d mismatches=%0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // Compares one result byte.
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Advances n edges and settles off the edge.
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    // Waits, bounded, for the system reset to reach a level.
    task automatic wait_rst(input logic lvl, input int lim);
        int i;
        for (i = 0; i < lim && sys_reset !== lvl; i++) cyc(1);
        wait_cycles = i;
        if (sys_reset !== lvl) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, sys_reset, lvl);
            tally_and_finish();
        end
    endtask
    // Reads a register and compares data and hit.
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp, input logic hit);
        core_u.rd(a, d, h);
        chk(d, exp);
        chk({7'h00, h}, {7'h00, hit});
    endtask
    initial begin
        cyc(8);
        reset_n = 1'b1;
        rchk(8'h87, 8'h10, 1'b1);
        rchk(8'h8E, 8'h00, 1'b1);
        rchk(8'h8F, 8'h00, 1'b1);
        rchk(8'h90, 8'h00, 1'b0);
        $display("test reset values done");
        core_u.wr(8'h87, 8'h0C);
        rchk(8'h87, 8'h0C, 1'b1);
        $display("test flags done");
        core_ale = 1'b1;
        core_u.wr(8'h8E, 8'h01);
        cyc(2);
        chk({7'h00, ale_out}, 8'h00);
        ext_access = 1'b1;
        cyc(2);
        chk({7'h00, ale_out}, 8'h01);
        ext_access = 1'b0;
        cyc(2);
        chk({7'h00, ale_out}, 8'h00);
        gain = 1'b0;
        tick0 = state_tick;
        cyc(1);
        chk({7'h00, state_tick}, {7'h00, ~tick0});
        clk_en = 1'b0;
        tick0 = state_tick;
        cyc(3);
        chk({7'h00, state_tick}, {7'h00, tick0});
        clk_en = 1'b1;
        cyc(1);
        chk({7'h00, osc_full_gain}, 8'h00);
        $display("test strobe and clock done");
        core_u.wr(8'h87, 8'h0D);
        cyc(2);
        chk({7'h00, cpu_clk_en}, 8'h00);
        irq_pending = 1'b1;
        cyc(3);
        chk({7'h00, cpu_clk_en}, 8'h01);
        irq_pending = 1'b0;
        rchk(8'h87, 8'h0C, 1'b1);
        $display("test idle done");
        core_u.wr(8'h8F, 8'h93);
        rchk(8'h8F, 8'h93, 1'b1);
        core_u.wr(8'h8F, 8'hD3);
        cyc(14);
        rchk(8'h8F, 8'h93, 1'b1);
        seen_rst = 1'b0;
        repeat (3) begin
            cyc(500);
            core_u.wr(8'h8F, 8'hD3);
        end
        chk({7'h00, seen_rst}, 8'h00);
        core_u.wr(8'h87, 8'h1C);
        core_u.wr(8'h8F, 8'hC2);
        wait_rst(1'b1, 300);
        chk({7'h00, (wait_cycles > TO_CYC && wait_cycles <= TO_CYC + 12)}, 8'h01);
        wait_rst(1'b0, 40);
        rchk(8'h8F, 8'h00, 1'b1);
        rchk(8'h87, 8'h10, 1'b1);
        rchk(8'h8E, 8'h00, 1'b1);
        $display("test watchdog done");
        seen_rst = 1'b0;
        core_u.pin(3);
        cyc(40);
        chk({7'h00, seen_rst}, 8'h00);
        fork
            core_u.pin(40);
            wait_rst(1'b1, 60);
        join
        wait_rst(1'b0, 40);
        rchk(8'h87, 8'h10, 1'b1);
        rchk(8'h8F, 8'h00, 1'b1);
        rchk(8'h8E, 8'h00, 1'b1);
        $display("test pin reset done");
        core_u.wr(8'h87, 8'h02);
        cyc(2);
        chk({6'h00, osc_run, cpu_clk_en}, 8'h00);
        irq_pending = 1'b1;
        cyc(20);
        chk({7'h00, osc_run}, 8'h00);
        irq_pending = 1'b0;
        core_u.pin(40);
        wait_rst(1'b0, 40);
        cyc(2);
        chk({6'h00, osc_run, cpu_clk_en}, 8'h03);
        $display("test power-down done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
